// >>> common/stack_unit_pkg.sv
// Constants, types and helpers of the stack pointer push/pop unit.
package stack_unit_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int PTR_W  = 64;
    localparam int DATA_W = 64;
    localparam int SEL_W  = 16;
    localparam int BYTE_W = 4;

    // ****************************************
    // Operations and address sizes
    // ****************************************
    typedef enum logic [2:0] {
        OP_PUSH,
        OP_POP,
        OP_PUSH_SEG,
        OP_LOAD_FAR,
        OP_LOAD_SEL,
        OP_LOAD_PTR
    } stack_op_e;

    typedef enum logic [1:0] {
        ASZ_16,
        ASZ_32,
        ASZ_64
    } asz_e;

    // ****************************************
    // Steps, masks and reset values
    // ****************************************
    localparam logic [BYTE_W-1:0] STEP_WORD  = 4'h2;
    localparam logic [BYTE_W-1:0] STEP_DWORD = 4'h4;
    localparam logic [BYTE_W-1:0] STEP_QWORD = 4'h8;
    localparam logic [PTR_W-1:0]  MASK_16    = 64'h0000_0000_0000_ffff;
    localparam logic [PTR_W-1:0]  MASK_32    = 64'h0000_0000_ffff_ffff;
    localparam logic [PTR_W-1:0]  PTR_RST    = 64'h0;
    localparam logic [SEL_W-1:0]  SEL_RST    = 16'h0;

    // Byte mask for a data item of the given size.
    function automatic logic [DATA_W-1:0] item_mask(
        input logic [BYTE_W-1:0] bytes);
        if (bytes == STEP_WORD) begin
            return MASK_16;
        end else if (bytes == STEP_DWORD) begin
            return MASK_32;
        end else begin
            return ~64'h0;
        end
    endfunction

endpackage

// >>> common/mem_req_if.sv
// Signals between the stack sequencer and its memory port.
interface mem_req_if;
    import stack_unit_pkg::*;

    logic                    req_valid;
    logic                    req_we;
    logic [PTR_W-1:0]        addr;
    logic [DATA_W-1:0]       wdata;
    logic [BYTE_W-1:0]       bytes;
    logic [SEL_W-1:0]        seg;
    logic                    busy;
    logic                    done;
    logic [DATA_W-1:0]       rdata;

    modport core (
        output req_valid, req_we, addr, wdata, bytes, seg,
        input  busy, done, rdata
    );

    modport port (
        input  req_valid, req_we, addr, wdata, bytes, seg,
        output busy, done, rdata
    );
endinterface

// >>> logic/stack_mem_port.sv
// Memory port that carries one stack access at a time.
module stack_mem_port
    import stack_unit_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    // Sequencer side
    mem_req_if.port                rq,
    // Stack memory pins
    output logic                   mem_req,
    output logic                   mem_we,
    output logic [SEL_W-1:0]       mem_seg,
    output logic [PTR_W-1:0]       mem_addr,
    output logic [DATA_W-1:0]      mem_wdata,
    output logic [BYTE_W-1:0]      mem_bytes,
    input  wire logic              mem_ack,
    input  wire logic [DATA_W-1:0] mem_rdata
);

    typedef enum logic {P_IDLE, P_WAIT} port_state_e;

    port_state_e       pstate_r;
    logic              done_r;
    logic [DATA_W-1:0] rdata_r;

    assign rq.busy  = (pstate_r != P_IDLE);
    assign rq.done  = done_r;
    assign rq.rdata = rdata_r;

    // ****************************************
    // Access sequence
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pstate_r  <= P_IDLE;
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            mem_seg   <= SEL_RST;
            mem_addr  <= PTR_RST;
            mem_wdata <= 64'h0;
            mem_bytes <= 4'h0;
            done_r    <= 1'b0;
        end else if (clk_en) begin
            done_r <= 1'b0;
            case (pstate_r)
                P_IDLE: begin
                    if (rq.req_valid) begin
                        mem_req   <= 1'b1;
                        mem_we    <= rq.req_we;
                        mem_seg   <= rq.seg;
                        mem_addr  <= rq.addr;
                        mem_wdata <= rq.wdata & item_mask(rq.bytes);
                        mem_bytes <= rq.bytes;
                        pstate_r  <= P_WAIT;
                    end
                end
                P_WAIT: begin
                    if (mem_ack) begin
                        mem_req  <= 1'b0;
                        done_r   <= 1'b1;
                        pstate_r <= P_IDLE;
                    end
                end
                default: pstate_r <= P_IDLE;
            endcase
        end
    end

    // Read data is held until the next read completes.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 64'h0;
        end else if (clk_en && pstate_r == P_WAIT && mem_ack && !mem_we) begin
            rdata_r <= mem_rdata & item_mask(mem_bytes);
        end
    end

endmodule

// >>> logic/stack_pointer_push_pop_unit.sv
// Stack pointer and stack segment unit that sequences push and pop.
// Summary of operation
// R1: Push decrements pointer, then writes new top.
// R2: Pop reads top first, then increments pointer.
// R3: Stack accesses always use stack segment selector.
// R4: All stack instructions act on current stack.
// R5: Step size follows code segment width flag.
// R6: Sixteen-bit push on wide stack stays uncorrected.
// R7: Segment selector push keeps full stack alignment.
// R8: No alignment check and no misalignment fault.
// R9: Software should keep the pointer aligned.
// R10: Stack and explicit operand have separate sizes.
// R11: Explicit size is width flag toggled by prefix.
// R12: Size sixteen uses sixteen-bit pointer, wraps FFFFH.
// R13: Stack segment size flag picks default size.
// R14: Stack segment may span full four gigabytes.
// R15: Software loads selector, then loads pointer.
// R16: Combined load writes selector and pointer together.
// R17: Exactly one stack is current at a time.
// R18: Long mode steps eight bytes, keeps alignment.
module stack_pointer_push_pop_unit
    import stack_unit_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    // Mode flags
    input  wire logic              code_d,
    input  wire logic              ss_big,
    input  wire logic              long_mode,
    input  wire logic              addr_prefix,
    // Operation request
    input  wire logic              op_valid,
    input  wire stack_op_e         op_kind,
    input  wire logic              item16,
    input  wire logic [DATA_W-1:0] push_data,
    input  wire logic [SEL_W-1:0]  sel_in,
    input  wire logic [PTR_W-1:0]  ptr_in,
    output logic                   op_ready,
    output logic                   op_done,
    output logic [DATA_W-1:0]      pop_data,
    // Stack state
    output logic [SEL_W-1:0]       ss_sel,
    output logic [15:0]            stack_pointer_16,
    output logic [31:0]            stack_pointer_32,
    output logic [PTR_W-1:0]       stack_pointer_full,
    output asz_e                   tos_asz,
    output asz_e                   explicit_asz,
    // Stack memory pins
    output logic                   mem_req,
    output logic                   mem_we,
    output logic [SEL_W-1:0]       mem_seg,
    output logic [PTR_W-1:0]       mem_addr,
    output logic [DATA_W-1:0]      mem_wdata,
    output logic [BYTE_W-1:0]      mem_bytes,
    input  wire logic              mem_ack,
    input  wire logic [DATA_W-1:0] mem_rdata
);

    // ****************************************
    // Helpers
    // ****************************************

    // Moves the pointer by a step, wrapping at the address size.
    function automatic logic [PTR_W-1:0] sp_move(
        input logic [PTR_W-1:0]  ptr,
        input logic [BYTE_W-1:0] step,
        input logic              down,
        input asz_e              asz);
        logic [PTR_W-1:0] delta;
        logic [PTR_W-1:0] sum;
        delta = {60'h0, step};
        sum   = down ? ptr - delta : ptr + delta;
        if (asz == ASZ_16) begin
            return {ptr[63:16], sum[15:0]};
        end else if (asz == ASZ_32) begin
            return {32'h0, sum[31:0]};
        end else begin
            return sum;
        end
    endfunction

    // Address of the top of stack for the given address size.
    function automatic logic [PTR_W-1:0] tos_addr(
        input logic [PTR_W-1:0] ptr,
        input asz_e             asz);
        if (asz == ASZ_16) begin
            return ptr & MASK_16;
        end else if (asz == ASZ_32) begin
            return ptr & MASK_32;
        end else begin
            return ptr;
        end
    endfunction

    // ****************************************
    // State
    // ****************************************
    typedef enum logic [2:0] {
        S_IDLE,
        S_PRE_DEC,
        S_ISSUE,
        S_WAIT,
        S_POST_INC
    } seq_state_e;

    seq_state_e        state_r;
    logic              push_r;
    logic [BYTE_W-1:0] step_r;
    logic [BYTE_W-1:0] item_r;
    asz_e              asz_r;
    logic [DATA_W-1:0] wdata_r;
    logic [PTR_W-1:0]  sp_r;
    logic [SEL_W-1:0]  ss_sel_r;
    logic              done_r;
    logic              op_fire;
    logic [BYTE_W-1:0] width_step;
    asz_e              tos_asz_nxt;

    mem_req_if rq ();

    stack_mem_port u_port (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .rq        (rq.port),
        .mem_req   (mem_req),
        .mem_we    (mem_we),
        .mem_seg   (mem_seg),
        .mem_addr  (mem_addr),
        .mem_wdata (mem_wdata),
        .mem_bytes (mem_bytes),
        .mem_ack   (mem_ack),
        .mem_rdata (mem_rdata)
    );

    // ****************************************
    // Size attributes
    // ****************************************
    always_comb begin
        if (long_mode) begin
            width_step  = STEP_QWORD;     // R18
            tos_asz_nxt = ASZ_64;         // R18
        end else begin
            width_step  = code_d ? STEP_DWORD : STEP_WORD;  // R5
            tos_asz_nxt = ss_big ? ASZ_32 : ASZ_16;         // R13
        end
    end

    // The explicit operand size is separate from the stack size.
    always_comb begin
        if (long_mode) begin
            explicit_asz = addr_prefix ? ASZ_32 : ASZ_64;   // R10
        end else if (code_d ^ addr_prefix) begin
            explicit_asz = ASZ_32;                          // R11
        end else begin
            explicit_asz = ASZ_16;                          // R11
        end
    end

    assign tos_asz  = tos_asz_nxt;    // R10
    assign op_ready = (state_r == S_IDLE);
    assign op_fire  = op_valid && op_ready && clk_en;
    assign op_done  = done_r;
    assign pop_data = rq.rdata;

    // ****************************************
    // Operation latch
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            push_r  <= 1'b0;
            step_r  <= STEP_WORD;
            item_r  <= STEP_WORD;
            asz_r   <= ASZ_16;
            wdata_r <= 64'h0;
        end else if (op_fire) begin
            push_r  <= (op_kind != OP_POP);
            asz_r   <= tos_asz_nxt;       // R12
            wdata_r <= (op_kind == OP_PUSH_SEG) ?
                       {48'h0, ss_sel_r} : push_data;
            if (op_kind == OP_PUSH_SEG) begin
                step_r <= width_step;     // R7 R18
                item_r <= STEP_WORD;
            end else if (item16) begin
                step_r <= STEP_WORD;      // R6
                item_r <= STEP_WORD;
            end else begin
                step_r <= width_step;     // R5
                item_r <= width_step;
            end
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= S_IDLE;
            done_r  <= 1'b0;
        end else if (clk_en) begin
            done_r <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    if (op_fire) begin
                        case (op_kind)
                            OP_PUSH, OP_PUSH_SEG: state_r <= S_PRE_DEC;
                            OP_POP:  state_r <= S_ISSUE;   // R2
                            default: done_r  <= 1'b1;
                        endcase
                    end
                end
                S_PRE_DEC: state_r <= S_ISSUE;             // R1
                S_ISSUE: begin
                    if (!rq.busy) begin
                        state_r <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (rq.done) begin
                        if (push_r) begin
                            state_r <= S_IDLE;
                            done_r  <= 1'b1;
                        end else begin
                            state_r <= S_POST_INC;         // R2
                        end
                    end
                end
                S_POST_INC: begin
                    state_r <= S_IDLE;
                    done_r  <= 1'b1;
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // Every access carries the current stack selector.
    always_comb begin
        rq.req_valid = (state_r == S_ISSUE) && !rq.busy;   // R4
        rq.req_we    = push_r;
        rq.addr      = tos_addr(sp_r, asz_r);              // R12 R14
        rq.wdata     = wdata_r;
        rq.bytes     = item_r;
        rq.seg       = ss_sel_r;                           // R3 R17
    end

    // ****************************************
    // Stack pointer and selector
    // ****************************************
    // The pointer moves freely; an odd value raises nothing.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sp_r <= PTR_RST;
        end else if (clk_en) begin
            if (op_fire && op_kind inside {OP_LOAD_FAR, OP_LOAD_PTR}) begin
                sp_r <= ptr_in;                            // R16
            end else if (state_r == S_PRE_DEC) begin
                sp_r <= sp_move(sp_r, step_r, 1'b1, asz_r);  // R1 R8
            end else if (state_r == S_POST_INC) begin
                sp_r <= sp_move(sp_r, step_r, 1'b0, asz_r);  // R2 R8
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ss_sel_r <= SEL_RST;
        end else if (op_fire && op_kind inside {OP_LOAD_FAR, OP_LOAD_SEL}) begin
            ss_sel_r <= sel_in;                            // R16 R17
        end
    end

    assign ss_sel             = ss_sel_r;
    assign stack_pointer_16   = sp_r[15:0];
    assign stack_pointer_32   = sp_r[31:0];
    assign stack_pointer_full = sp_r;

    // ****************************************
    // Assertions
    // ****************************************
    property p_push_dec;
        @(posedge core_clk) disable iff (!rst_n || !clk_en)
        state_r == S_PRE_DEC |=>
            sp_r == sp_move($past(sp_r), $past(step_r), 1'b1, $past(asz_r))
            && state_r == S_ISSUE;
    endproperty
    a_push_dec: assert property (p_push_dec) // R1
        else $error("push write before decrement");

    property p_write_new_top;
        @(posedge core_clk) disable iff (!rst_n || !clk_en)
        (rq.req_valid && rq.req_we) |->
            rq.addr == tos_addr(sp_r, asz_r) && $past(state_r) == S_PRE_DEC;
    endproperty
    a_write_new_top: assert property (p_write_new_top) // R1
        else $error("push write not at new top");

    property p_pop_hold;
        @(posedge core_clk) disable iff (!rst_n || !clk_en)
        (state_r == S_WAIT && !push_r) |=> sp_r == $past(sp_r);
    endproperty
    a_pop_hold: assert property (p_pop_hold) // R2
        else $error("pointer moved before pop read");

    property p_seg_current;
        @(posedge core_clk) disable iff (!rst_n || !clk_en)
        rq.req_valid |=> mem_req && mem_seg == $past(ss_sel_r);
    endproperty
    a_seg_current: assert property (p_seg_current) // R3
        else $error("access not in stack segment");

    property p_step_width;
        @(posedge core_clk) disable iff (!rst_n || !clk_en)
        (op_fire && op_kind == OP_POP && !item16 && !long_mode) |=>
            step_r == ($past(code_d) ? STEP_DWORD : STEP_WORD);
    endproperty
    a_step_width: assert property (p_step_width) // R5
        else $error("pop step ignores width flag");

    property p_seg_align;
        @(posedge core_clk) disable iff (!rst_n || !clk_en)
        (op_fire && op_kind == OP_PUSH_SEG && code_d && !long_mode) |=>
            step_r == STEP_DWORD && item_r == STEP_WORD;
    endproperty
    a_seg_align: assert property (p_seg_align) // R7
        else $error("selector push lost alignment");

    property p_short_push;
        @(posedge core_clk) disable iff (!rst_n || !clk_en)
        (op_fire && op_kind == OP_PUSH && item16) |=> step_r == STEP_WORD;
    endproperty
    a_short_push: assert property (p_short_push) // R6
        else $error("short push step corrected");

    property p_addr16;
        @(posedge core_clk) disable iff (!rst_n || !clk_en)
        (rq.req_valid && asz_r == ASZ_16) |-> rq.addr[63:16] == 48'h0;
    endproperty
    a_addr16: assert property (p_addr16) // R12
        else $error("16-bit stack address above FFFFH");

    property p_far_load;
        @(posedge core_clk) disable iff (!rst_n || !clk_en)
        (op_fire && op_kind == OP_LOAD_FAR) |=>
            ss_sel_r == $past(sel_in) && sp_r == $past(ptr_in) && op_done;
    endproperty
    a_far_load: assert property (p_far_load) // R16
        else $error("combined load failed");

    property p_long_step;
        @(posedge core_clk) disable iff (!rst_n || !clk_en)
        (op_fire && long_mode && !item16) |=> step_r == STEP_QWORD;
    endproperty
    a_long_step: assert property (p_long_step) // R18
        else $error("long mode step not eight bytes");

    property p_explicit;
        @(posedge core_clk) disable iff (!rst_n || !clk_en)
        !long_mode |-> (explicit_asz == ASZ_32) == (code_d ^ addr_prefix);
    endproperty
    a_explicit: assert property (p_explicit) // R11
        else $error("explicit operand size wrong");

endmodule

// >>> testbench/stack_mem_model.sv
// Behavioural model of the memory that holds the current stack segment.
module stack_mem_model
    import stack_unit_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    // Request from the unit
    input  wire logic              mem_req,
    input  wire logic              mem_we,
    input  wire logic [SEL_W-1:0]  mem_seg,
    input  wire logic [PTR_W-1:0]  mem_addr,
    input  wire logic [DATA_W-1:0] mem_wdata,
    input  wire logic [BYTE_W-1:0] mem_bytes,
    // Answer to the unit
    output logic                   mem_ack,
    output logic [DATA_W-1:0]      mem_rdata
);
    timeunit 1ns;
    timeprecision 100ps;

    int                 delay = 0;
    int                 wait_cnt;
    logic [DATA_W-1:0]  store [logic [PTR_W-1:0]];
    logic [PTR_W-1:0]   last_addr;
    logic [SEL_W-1:0]   last_seg;
    logic [BYTE_W-1:0]  last_bytes;
    logic [DATA_W-1:0]  last_wdata;
    logic               last_we;

    // ****************************************
    // Answer
    // ****************************************
    // Answers after delay wait cycles; idle read lines show the inverse.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_ack   <= 1'b0;
            mem_rdata <= 64'h0;
            wait_cnt  <= 0;
        end else if (mem_ack) begin
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end else if (mem_req && wait_cnt < delay) begin
            wait_cnt <= wait_cnt + 1;
        end else if (mem_req) begin
            wait_cnt   <= 0;
            mem_ack    <= 1'b1;
            last_addr  <= mem_addr;
            last_seg   <= mem_seg;
            last_bytes <= mem_bytes;
            last_wdata <= mem_wdata;
            last_we    <= mem_we;
            if (mem_we) begin
                store[mem_addr] = mem_wdata;
            end else if (store.exists(mem_addr)) begin
                mem_rdata <= store[mem_addr];
            end else begin
                mem_rdata <= ~mem_rdata;
            end
        end
    end
endmodule

// >>> testbench/test_stack_pointer_push_pop_unit.sv
// Self-checking testbench of the stack pointer push/pop unit.
module test_stack_pointer_push_pop_unit;
    timeunit 1ns;
    timeprecision 100ps;
    import stack_unit_pkg::*;

    typedef struct {
        stack_op_e         kind;
        logic [3:0]        mode;
        logic [DATA_W-1:0] data;
        logic [PTR_W-1:0]  ptr;
        logic [SEL_W-1:0]  sel;
        logic [PTR_W-1:0]  sp;
        logic [PTR_W-1:0]  addr;
        logic [BYTE_W-1:0] bytes;
    } row_s;

    logic core_clk = 0, rst_n = 0, code_d = 0, ss_big = 0, long_mode = 0;
    logic addr_prefix = 0, op_valid = 0, item16 = 0, op_ready, op_done;
    stack_op_e         op_kind = OP_PUSH;
    logic [DATA_W-1:0] push_data = 0, pop_data, mem_wdata, mem_rdata;
    logic [SEL_W-1:0]  sel_in = 0, ss_sel, mem_seg, exp_seg;
    logic [PTR_W-1:0]  ptr_in = 0, stack_pointer_full, mem_addr;
    logic [15:0]       stack_pointer_16;
    logic [31:0]       stack_pointer_32;
    logic [BYTE_W-1:0] mem_bytes;
    logic              mem_req, mem_we, mem_ack;
    asz_e              tos_asz, explicit_asz, exp_tos, exp_exp;
    int                miscompares = 0, n_compared = 0;
    row_s              rows [16];

    // ****************************************
    // Design, memory and clock
    // ****************************************
    stack_pointer_push_pop_unit dut (.core_clk(core_clk), .rst_n(rst_n),
        .clk_en(1'b1), .code_d(code_d), .ss_big(ss_big),
        .long_mode(long_mode), .addr_prefix(addr_prefix),
        .op_valid(op_valid), .op_kind(op_kind), .item16(item16),
        .push_data(push_data), .sel_in(sel_in), .ptr_in(ptr_in),
        .op_ready(op_ready), .op_done(op_done), .pop_data(pop_data),
        .ss_sel(ss_sel), .stack_pointer_16(stack_pointer_16),
        .stack_pointer_32(stack_pointer_32),
        .stack_pointer_full(stack_pointer_full), .tos_asz(tos_asz),
        .explicit_asz(explicit_asz), .mem_req(mem_req), .mem_we(mem_we),
        .mem_seg(mem_seg), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_bytes(mem_bytes), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    stack_mem_model mdl (.core_clk(core_clk), .rst_n(rst_n),
        .mem_req(mem_req), .mem_we(mem_we), .mem_seg(mem_seg),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_bytes(mem_bytes),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    initial begin
        forever #2 core_clk = ~core_clk;
    end

    // ****************************************
    // Checking and closing
    // ****************************************
    task automatic check_val(string name, logic [63:0] exp, logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_asz(string name, asz_e exp, asz_e got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic do_reset();
        @(negedge core_clk);
        rst_n = 0;
        repeat (5) @(negedge core_clk);
        check_val("ready in reset", 1, op_ready);
        check_val("pointer in reset", 0, stack_pointer_full);
        check_val("selector in reset", 0, ss_sel);
        check_val("request in reset", 0, mem_req);
        rst_n = 1;
        exp_seg = 0;
    endtask

    task automatic run_row(row_s r);
        int n;
        logic [DATA_W-1:0] mask;
        @(negedge core_clk);
        {code_d, ss_big, long_mode, item16} = r.mode;
        op_kind = r.kind;
        push_data = r.data;
        ptr_in = r.ptr;
        sel_in = r.sel;
        op_valid = 1;
        @(negedge core_clk);
        op_valid = 0;
        for (n = 0; n < 60 && op_done !== 1'b1; n++) begin
            @(negedge core_clk);
        end
        check_val("done", 1, op_done);
        check_val("ready", 1, op_ready);
        if (r.kind == OP_LOAD_FAR || r.kind == OP_LOAD_SEL) begin
            exp_seg = r.sel;
        end
        check_val("selector", exp_seg, ss_sel);
        check_val("pointer", r.sp, stack_pointer_full);
        check_val("pointer 16", r.sp[15:0], stack_pointer_16);
        check_val("pointer 32", r.sp[31:0], stack_pointer_32);
        if (r.kind inside {OP_PUSH, OP_POP, OP_PUSH_SEG}) begin
            mask = ~64'h0 >> (64 - 8 * r.bytes);
            check_val("address", r.addr, mdl.last_addr);
            check_val("segment", exp_seg, mdl.last_seg);
            check_val("size", r.bytes, mdl.last_bytes);
            check_val("write", r.kind != OP_POP, mdl.last_we);
            if (r.kind == OP_POP) begin
                check_val("pop data", r.data & mask, pop_data);
            end else if (r.kind == OP_PUSH) begin
                check_val("push data", r.data & mask, mdl.last_wdata);
            end else begin
                check_val("seg data", exp_seg, mdl.last_wdata);
            end
        end
    endtask

    initial begin
        #80000;
        miscompares++;
        report_and_stop();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        // Mode bits are code_d, ss_big, long_mode, item16.
        rows = '{
            '{OP_LOAD_FAR, 4'b1100, 0, 64'h1000, 16'h23, 64'h1000, 0, 0},
            '{OP_PUSH, 4'b1100, 64'h1122_3344_aabb_ccdd, 0, 0,
              64'hffc, 64'hffc, 4'h4},
            '{OP_PUSH, 4'b1101, 64'h9999_5555, 0, 0, 64'hffa, 64'hffa, 4'h2},
            '{OP_POP, 4'b1101, 64'h5555, 0, 0, 64'hffc, 64'hffa, 4'h2},
            '{OP_POP, 4'b1100, 64'haabb_ccdd, 0, 0, 64'h1000, 64'hffc, 4'h4},
            '{OP_PUSH_SEG, 4'b1100, 0, 0, 0, 64'hffc, 64'hffc, 4'h2},
            '{OP_LOAD_SEL, 4'b0000, 0, 0, 16'h47, 64'hffc, 0, 0},
            '{OP_LOAD_PTR, 4'b0000, 0, 64'h1_0000, 0, 64'h1_0000, 0, 0},
            '{OP_PUSH, 4'b0001, 64'h7777_1234, 0, 0,
              64'h1_fffe, 64'hfffe, 4'h2},
            '{OP_POP, 4'b0001, 64'h1234, 0, 0, 64'h1_0000, 64'hfffe, 4'h2},
            '{OP_LOAD_PTR, 4'b1100, 0, 64'h2, 0, 64'h2, 0, 0},
            '{OP_PUSH, 4'b1100, 64'h0bad_f00d, 0, 0,
              64'hffff_fffe, 64'hffff_fffe, 4'h4},
            '{OP_LOAD_PTR, 4'b0010, 0, 64'h8000_0000_0010, 0,
              64'h8000_0000_0010, 0, 0},
            '{OP_PUSH, 4'b0010, 64'h0102_0304_0506_0708, 0, 0,
              64'h8000_0000_0008, 64'h8000_0000_0008, 4'h8},
            '{OP_PUSH_SEG, 4'b0010, 0, 0, 0,
              64'h8000_0000_0000, 64'h8000_0000_0000, 4'h2},
            '{OP_POP, 4'b0010, 64'h47, 0, 0,
              64'h8000_0000_0008, 64'h8000_0000_0000, 4'h8}};
        do_reset();
        for (int d = 0; d < 5; d += 4) begin
            mdl.delay = d;
            foreach (rows[i]) run_row(rows[i]);
        end
        for (int m = 0; m < 16; m++) begin
            {code_d, ss_big, long_mode, addr_prefix} = m[3:0];
            @(negedge core_clk);
            exp_tos = long_mode ? ASZ_64 : ss_big ? ASZ_32 : ASZ_16;
            exp_exp = long_mode ? (addr_prefix ? ASZ_32 : ASZ_64)
                    : ((code_d ^ addr_prefix) ? ASZ_32 : ASZ_16);
            check_asz("top size", exp_tos, tos_asz);
            check_asz("operand size", exp_exp, explicit_asz);
        end
        addr_prefix = 0;
        run_row(rows[0]);
        do_reset();
        run_row(rows[0]);
        run_row(rows[1]);
        report_and_stop();
    end
endmodule
